/* bbc_pkg.sv */
// shared constants and types for the backlight brightness controller
package bbc_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int HZ_PER_MHZ = 1_000_000;
  localparam int SLOW_RATE_HZ = 1_000_000;
  localparam int FAST_RATE_HZ = 4_000_000;

  // fractional sample divider: accumulate inc per clock, wrap at mod
  localparam logic [3:0] SAMPLE_MOD = 4'(CLK_HZ / SLOW_RATE_HZ);
  localparam logic [3:0] SAMPLE_INC_SLOW = 4'h1;
  localparam logic [3:0] SAMPLE_INC_FAST = 4'(FAST_RATE_HZ / SLOW_RATE_HZ);

  // low-level timeout of the duty detector, in microseconds
  localparam int TIMEOUT_SLOW_US = 25000;
  localparam int TIMEOUT_FAST_US = 3000;

  // register offsets
  localparam logic [7:0] REG_MAP_CFG = 8'h02;
  localparam logic [7:0] REG_SAMPLE_CFG = 8'h03;
  localparam logic [7:0] REG_BRT_LOW = 8'h04;
  localparam logic [7:0] REG_BRT_HIGH = 8'h05;
  localparam logic [7:0] REG_PWM_CTRL = 8'h09;
  localparam logic [7:0] REG_BACKLIGHT_MASTER_ENABLE = 8'h0a;
  localparam logic [7:0] REG_STATUS = 8'h0c;

  // field positions and widths
  localparam int POLARITY_BIT = 3;
  localparam int RATE_BIT = 2;
  localparam int PWM_EN_BIT = 6;
  localparam int MASTER_BIT = 0;
  localparam int SINK_ONE_BIT = 4;
  localparam int SINK_TWO_BIT = 3;
  localparam int LOW_BITS = 3;
  localparam int CODE_W = 11;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [10:0] CODE_FULL = 11'h7ff;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] DIV_LAST_STEP = 4'ha;

  // bus address of the device, value arbitrary
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2b;

  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_RX = 3'b001,
    I2C_ACK = 3'b010,
    I2C_TX = 3'b011,
    I2C_TXACK = 3'b100
  } bbc_i2c_state_t;

  typedef enum logic [1:0] {
    KIND_ADDR = 2'b00,
    KIND_PTR = 2'b01,
    KIND_DATA = 2'b10
  } bbc_kind_t;

endpackage

/* bbc_i2c_slave.sv */
// serial register port slave: byte writes and reads with auto-incrementing pointer
`timescale 1ns/1ps
module bbc_i2c_slave #(
  parameter logic [6:0] DEV_ADDR = bbc_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic wr_stb,
  output logic [7:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_d;
    logic sda_s1;
    logic sda_s2;
    logic sda_d;
    bbc_pkg::bbc_i2c_state_t st;
    bbc_pkg::bbc_kind_t kind;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic mack;
    logic [7:0] ptr;
    logic drive_low;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
  } bbc_i2c_st_t;

  bbc_i2c_st_t s;
  bbc_i2c_st_t next_s;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = s.scl_s2 & ~s.scl_d;
  assign scl_fall = ~s.scl_s2 & s.scl_d;
  assign start_cond = s.scl_s2 & s.scl_d & s.sda_d & ~s.sda_s2;
  assign stop_cond = s.scl_s2 & s.scl_d & ~s.sda_d & s.sda_s2;

  always_comb
  begin
    next_s = s;
    next_s.scl_s1 = scl;
    next_s.scl_s2 = s.scl_s1;
    next_s.scl_d = s.scl_s2;
    next_s.sda_s1 = sda_in;
    next_s.sda_s2 = s.sda_s1;
    next_s.sda_d = s.sda_s2;
    next_s.wr_stb = 1'b0;
    if (start_cond)
    begin
      next_s.st = bbc_pkg::I2C_RX;
      next_s.kind = bbc_pkg::KIND_ADDR;
      next_s.cnt = 4'h0;
      next_s.drive_low = 1'b0;
    end
    else if (stop_cond)
    begin
      next_s.st = bbc_pkg::I2C_IDLE;
      next_s.drive_low = 1'b0;
    end
    else
    begin
      unique case (s.st)
        bbc_pkg::I2C_IDLE:
        begin
          next_s.drive_low = 1'b0;
        end
        bbc_pkg::I2C_RX:
        begin
          if (scl_rise && s.cnt < bbc_pkg::BITS_PER_BYTE)
          begin
            next_s.sh = {s.sh[6:0], s.sda_s2};
            next_s.cnt = s.cnt + 4'h1;
          end
          else if (scl_fall && s.cnt == bbc_pkg::BITS_PER_BYTE)
          begin
            next_s.st = bbc_pkg::I2C_ACK;
            next_s.drive_low = 1'b1;
            unique case (s.kind)
              bbc_pkg::KIND_ADDR:
              begin
                next_s.rd = s.sh[0];
                if (s.sh[7:1] != DEV_ADDR)
                begin
                  next_s.st = bbc_pkg::I2C_IDLE;
                  next_s.drive_low = 1'b0;
                end
              end
              bbc_pkg::KIND_PTR:
              begin
                next_s.ptr = s.sh;
              end
              default:
              begin
                next_s.wr_stb = 1'b1;
                next_s.wr_addr = s.ptr;
                next_s.wr_data = s.sh;
                next_s.ptr = s.ptr + 8'h01;
              end
            endcase
          end
        end
        bbc_pkg::I2C_ACK:
        begin
          if (scl_fall)
          begin
            if (s.kind == bbc_pkg::KIND_ADDR && s.rd)
            begin
              next_s.st = bbc_pkg::I2C_TX;
              next_s.sh = rd_data;
              next_s.ptr = s.ptr + 8'h01;
              next_s.drive_low = ~rd_data[7];
              next_s.cnt = 4'h1;
            end
            else
            begin
              next_s.st = bbc_pkg::I2C_RX;
              next_s.cnt = 4'h0;
              next_s.drive_low = 1'b0;
              next_s.kind = (s.kind == bbc_pkg::KIND_ADDR) ? bbc_pkg::KIND_PTR
                                                            : bbc_pkg::KIND_DATA;
            end
          end
        end
        bbc_pkg::I2C_TX:
        begin
          if (scl_fall)
          begin
            if (s.cnt == bbc_pkg::BITS_PER_BYTE)
            begin
              next_s.drive_low = 1'b0;
              next_s.st = bbc_pkg::I2C_TXACK;
            end
            else
            begin
              next_s.drive_low = ~s.sh[6];
              next_s.sh = {s.sh[6:0], 1'b0};
              next_s.cnt = s.cnt + 4'h1;
            end
          end
        end
        bbc_pkg::I2C_TXACK:
        begin
          if (scl_rise)
          begin
            next_s.mack = ~s.sda_s2;
          end
          else if (scl_fall)
          begin
            if (s.mack)
            begin
              next_s.st = bbc_pkg::I2C_TX;
              next_s.sh = rd_data;
              next_s.ptr = s.ptr + 8'h01;
              next_s.drive_low = ~rd_data[7];
              next_s.cnt = 4'h1;
            end
            else
            begin
              next_s.st = bbc_pkg::I2C_IDLE;
            end
          end
        end
        default:
        begin
          next_s.st = bbc_pkg::I2C_IDLE;
          next_s.drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '{scl_s1: 1'b1, scl_s2: 1'b1, scl_d: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
             sda_d: 1'b1, st: bbc_pkg::I2C_IDLE, kind: bbc_pkg::KIND_ADDR,
             default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe = s.drive_low;
  assign wr_stb = s.wr_stb;
  assign wr_addr = s.wr_addr;
  assign wr_data = s.wr_data;
  assign rd_addr = s.ptr;

endmodule

/* bbc_pwm_detect.sv */
// duty detector for the external dimming input with low-level timeout
`timescale 1ns/1ps
module bbc_pwm_detect #(
  parameter int TIMEOUT_SLOW_US = bbc_pkg::TIMEOUT_SLOW_US,
  parameter int TIMEOUT_FAST_US = bbc_pkg::TIMEOUT_FAST_US
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pwm,
  input wire logic enable,
  input wire logic invert,
  input wire logic rate_fast,
  output logic [10:0] duty,
  output logic timed_out
);

  localparam logic [15:0] LIM_SLOW =
    16'(TIMEOUT_SLOW_US * (bbc_pkg::SLOW_RATE_HZ / bbc_pkg::HZ_PER_MHZ));
  localparam logic [15:0] LIM_FAST =
    16'(TIMEOUT_FAST_US * (bbc_pkg::FAST_RATE_HZ / bbc_pkg::HZ_PER_MHZ));

  typedef struct packed {
    logic pwm_s1;
    logic pwm_s2;
    logic lvl_d;
    logic [3:0] acc;
    logic tick;
    logic seen;
    logic [15:0] per;
    logic [15:0] high;
    logic busy;
    logic [3:0] dcnt;
    logic [16:0] rem;
    logic [15:0] divisor;
    logic [10:0] quo;
    logic [10:0] duty;
    logic timed_out;
  } bbc_det_st_t;

  bbc_det_st_t s;
  bbc_det_st_t next_s;
  logic lvl;
  logic [4:0] acc_sum;
  logic [16:0] rem_sh;
  logic [10:0] quo_next;
  logic [15:0] limit;

  assign lvl = s.pwm_s2 ^ invert;
  assign limit = rate_fast ? LIM_FAST : LIM_SLOW;
  assign acc_sum = {1'b0, s.acc} +
                   {1'b0, rate_fast ? bbc_pkg::SAMPLE_INC_FAST : bbc_pkg::SAMPLE_INC_SLOW};
  assign rem_sh = {s.rem[15:0], 1'b0};

  always_comb
  begin
    next_s = s;
    quo_next = s.quo;
    next_s.pwm_s1 = pwm;
    next_s.pwm_s2 = s.pwm_s1;
    if (acc_sum >= {1'b0, bbc_pkg::SAMPLE_MOD})
    begin
      next_s.acc = 4'(acc_sum - {1'b0, bbc_pkg::SAMPLE_MOD});
      next_s.tick = 1'b1;
    end
    else
    begin
      next_s.acc = acc_sum[3:0];
      next_s.tick = 1'b0;
    end
    // duty = high * 2048 / period, one quotient bit per clock
    if (s.busy)
    begin
      if (rem_sh >= {1'b0, s.divisor})
      begin
        next_s.rem = rem_sh - {1'b0, s.divisor};
        quo_next = {s.quo[9:0], 1'b1};
      end
      else
      begin
        next_s.rem = rem_sh;
        quo_next = {s.quo[9:0], 1'b0};
      end
      next_s.quo = quo_next;
      next_s.dcnt = s.dcnt + 4'h1;
      if (s.dcnt == bbc_pkg::DIV_LAST_STEP)
      begin
        next_s.busy = 1'b0;
        next_s.duty = quo_next;
        next_s.timed_out = 1'b0;
      end
    end
    if (s.tick)
    begin
      next_s.lvl_d = lvl;
      if (lvl && !s.lvl_d)
      begin
        // period closes and timeout restarts at each rising edge
        if (s.seen && s.per != 16'h0000)
        begin
          next_s.busy = 1'b1;
          next_s.rem = {1'b0, s.high};
          next_s.divisor = s.per;
          next_s.quo = 11'h000;
          next_s.dcnt = 4'h0;
        end
        next_s.seen = 1'b1;
        next_s.per = 16'h0001;
        next_s.high = 16'h0001;
      end
      else if (s.per < limit)
      begin
        next_s.per = s.per + 16'h0001;
        next_s.high = s.high + {15'h0000, lvl};
      end
      else
      begin
        // no edge within timeout: held high is full duty, held low shuts down
        next_s.seen = 1'b0;
        next_s.busy = 1'b0;
        next_s.duty = lvl ? bbc_pkg::CODE_FULL : 11'h000;
        next_s.timed_out = ~lvl;
      end
    end
    if (!enable)
    begin
      next_s.seen = 1'b0;
      next_s.busy = 1'b0;
      next_s.per = 16'h0000;
      next_s.high = 16'h0000;
      next_s.duty = 11'h000;
      next_s.timed_out = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign duty = s.duty;
  assign timed_out = s.timed_out;

endmodule

/* bbc_top.sv */
// backlight enable and brightness control with register port and duty input
`timescale 1ns/1ps
module bbc_top #(
  parameter int TIMEOUT_SLOW_US = bbc_pkg::TIMEOUT_SLOW_US,
  parameter int TIMEOUT_FAST_US = bbc_pkg::TIMEOUT_FAST_US,
  parameter logic [6:0] DEV_ADDR = bbc_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic pwm,
  output logic backlight_on,
  output logic sink_one_on,
  output logic sink_two_on,
  output logic [10:0] target_code,
  output logic brightness_update
);

  typedef struct packed {
    logic en_s1;
    logic en_s2;
    logic [7:0] map_cfg;
    logic [7:0] sample_cfg;
    logic [7:0] brt_low;
    logic [7:0] brt_high;
    logic [7:0] pwm_ctrl;
    logic [7:0] backlight_master_enable;
    logic [10:0] active_code;
    logic bl_on;
    logic s1_on;
    logic s2_on;
    logic [10:0] target;
    logic upd;
  } bbc_top_st_t;

  bbc_top_st_t s;
  bbc_top_st_t next_s;

  logic wr_stb;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [10:0] duty;
  logic timed_out;
  logic chip_on;
  logic pwm_mode;
  logic master;
  logic any_sink;
  logic det_enable;
  logic [21:0] product;
  logic [10:0] eff_code;
  logic on_now;

  assign chip_on = s.en_s2;
  assign pwm_mode = s.pwm_ctrl[bbc_pkg::PWM_EN_BIT];
  assign master = s.backlight_master_enable[bbc_pkg::MASTER_BIT];
  assign any_sink = s.backlight_master_enable[bbc_pkg::SINK_ONE_BIT] | s.backlight_master_enable[bbc_pkg::SINK_TWO_BIT];
  assign det_enable = chip_on & master & pwm_mode;

  bbc_i2c_slave #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .clk(clk),
    .nrst(nrst),
    .scl(scl),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .wr_stb(wr_stb),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  bbc_pwm_detect #(
    .TIMEOUT_SLOW_US(TIMEOUT_SLOW_US),
    .TIMEOUT_FAST_US(TIMEOUT_FAST_US)
  ) u_detect (
    .clk(clk),
    .nrst(nrst),
    .pwm(pwm),
    .enable(det_enable),
    .invert(s.map_cfg[bbc_pkg::POLARITY_BIT]),
    .rate_fast(s.sample_cfg[bbc_pkg::RATE_BIT]),
    .duty(duty),
    .timed_out(timed_out)
  );

  function automatic logic [7:0] reg_read(input logic [7:0] addr, input bbc_top_st_t st,
                                          input logic tmo);
    logic [7:0] v;
    v = 8'h00;
    case (addr)
      bbc_pkg::REG_MAP_CFG: v = st.map_cfg;
      bbc_pkg::REG_SAMPLE_CFG: v = st.sample_cfg;
      bbc_pkg::REG_BRT_LOW: v = st.brt_low;
      bbc_pkg::REG_BRT_HIGH: v = st.brt_high;
      bbc_pkg::REG_PWM_CTRL: v = st.pwm_ctrl;
      bbc_pkg::REG_BACKLIGHT_MASTER_ENABLE: v = st.backlight_master_enable;
      bbc_pkg::REG_STATUS: v = {6'h00, tmo, st.bl_on};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign rd_data = reg_read(rd_addr, s, timed_out);

  // register code scaled by measured duty, duty full scale is 2048
  assign product = 22'(s.active_code) * 22'(duty);
  assign eff_code = pwm_mode ? product[21:11] : s.active_code;

  assign on_now = chip_on & master & any_sink & (s.active_code != 11'h000)
                  & (eff_code != 11'h000) & ~(pwm_mode & timed_out);

  always_comb
  begin
    next_s = s;
    next_s.en_s1 = en;
    next_s.en_s2 = s.en_s1;
    next_s.upd = 1'b0;
    if (!chip_on)
    begin
      // chip disabled: registers return to their reset values
      next_s.map_cfg = bbc_pkg::REG_RESET;
      next_s.sample_cfg = bbc_pkg::REG_RESET;
      next_s.brt_low = bbc_pkg::REG_RESET;
      next_s.brt_high = bbc_pkg::REG_RESET;
      next_s.pwm_ctrl = bbc_pkg::REG_RESET;
      next_s.backlight_master_enable = bbc_pkg::REG_RESET;
      next_s.active_code = 11'h000;
    end
    else if (wr_stb)
    begin
      case (wr_addr)
        bbc_pkg::REG_MAP_CFG: next_s.map_cfg = wr_data;
        bbc_pkg::REG_SAMPLE_CFG: next_s.sample_cfg = wr_data;
        bbc_pkg::REG_BRT_LOW: next_s.brt_low = wr_data;
        bbc_pkg::REG_BRT_HIGH:
        begin
          next_s.brt_high = wr_data;
          next_s.active_code = {wr_data, s.brt_low[bbc_pkg::LOW_BITS-1:0]};
          next_s.upd = 1'b1;
        end
        bbc_pkg::REG_PWM_CTRL: next_s.pwm_ctrl = wr_data;
        bbc_pkg::REG_BACKLIGHT_MASTER_ENABLE: next_s.backlight_master_enable = wr_data;
        default: next_s.upd = 1'b0;
      endcase
    end
    next_s.bl_on = on_now;
    next_s.s1_on = on_now & s.backlight_master_enable[bbc_pkg::SINK_ONE_BIT];
    next_s.s2_on = on_now & s.backlight_master_enable[bbc_pkg::SINK_TWO_BIT];
    next_s.target = on_now ? eff_code : 11'h000;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign backlight_on = s.bl_on;
  assign sink_one_on = s.s1_on;
  assign sink_two_on = s.s2_on;
  assign target_code = s.target;
  assign brightness_update = s.upd;

endmodule

/* bbc_top_sva.sv */
// pin-level assertions for the backlight brightness controller
`timescale 1ns/1ps
module bbc_top_sva #(
  parameter int TIMEOUT_SLOW_US = 25000,
  parameter int TIMEOUT_FAST_US = 3000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic en,
  input wire logic scl,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic pwm,
  input wire logic backlight_on,
  input wire logic sink_one_on,
  input wire logic sink_two_on,
  input wire logic [10:0] target_code,
  input wire logic brightness_update
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // chip enable pin held low long enough to pass sync and clear
  sequence chip_held_off;
    !en [*8];
  endsequence
  sequence update_then_quiet;
    brightness_update ##1 !brightness_update;
  endsequence

  a_on_has_sink: assert property (backlight_on |-> (sink_one_on || sink_two_on))
    else $error("backlight on with both sinks off");
  a_sink_one_gated: assert property (sink_one_on |-> backlight_on)
    else $error("sink one on while backlight off");
  a_sink_two_gated: assert property (sink_two_on |-> backlight_on)
    else $error("sink two on while backlight off");
  a_on_nonzero_code: assert property (backlight_on |-> target_code != 11'h000)
    else $error("backlight on with zero code");
  a_off_zero_code: assert property (!backlight_on |-> target_code == 11'h000)
    else $error("code driven while backlight off");
  a_update_one_cycle: assert property (brightness_update |-> update_then_quiet)
    else $error("update pulse longer than one cycle");
  a_update_in_ack: assert property (brightness_update |-> !scl)
    else $error("update outside the low phase of the ack bit");
  a_chip_off_dark: assert property (chip_held_off |-> !backlight_on && !sink_one_on)
    else $error("backlight on with chip disabled");
  a_release_dark: assert property ($rose(nrst) |-> !backlight_on && !brightness_update)
    else $error("backlight on right after reset");
endmodule

/* bbc_pwm_src.sv */
// behavioural dimming source standing in for the display controller
`timescale 1ns/1ps
module bbc_pwm_src (
  input wire logic clk,
  input wire logic run,
  input wire logic [7:0] high_cyc,
  input wire logic [7:0] low_cyc,
  output logic pwm = 1'b0
);
  logic [7:0] cnt = 8'h00;
  logic in_high = 1'b0;

  // a started period always runs to the end of its low phase
  always @(posedge clk)
  begin
    if (cnt != 8'h00)
      cnt <= cnt - 8'h01;
    else if (in_high)
    begin
      pwm <= 1'b0;
      in_high <= 1'b0;
      cnt <= low_cyc - 8'h01;
    end
    else if (run)
    begin
      pwm <= 1'b1;
      in_high <= 1'b1;
      cnt <= high_cyc - 8'h01;
    end
  end
endmodule

/* bbc_top_tb.sv */
// self-checking bench for the backlight brightness controller
`timescale 1ns/1ps
module bbc_top_tb;
  localparam int Q = 8;
  localparam logic [6:0] ADDR = bbc_pkg::DEV_ADDR_DEFAULT;
  localparam logic [7:0] OFFS [5] = '{8'h04, 8'h05, 8'h09, 8'h0a, 8'h20};
  localparam logic [7:0] EN_VAL [4] = '{8'h11, 8'h09, 8'h01, 8'h18};
  localparam logic [2:0] EN_EXP [4] = '{3'b110, 3'b101, 3'b000, 3'b000};
  logic clk, nrst, en, scl, sda_m, sda_w, run;
  logic [7:0] hi_cyc, lo_cyc;
  logic sda_out, sda_oe, pwm, backlight_on, sink_one_on, sink_two_on, brightness_update;
  logic [10:0] target_code;
  int failures = 0;
  int n_checks = 0;
  int n_upd = 0;

  // open-drain wire with pull-up
  assign sda_w = sda_m && !(sda_oe && !sda_out);

  bbc_top #(.TIMEOUT_SLOW_US(20), .TIMEOUT_FAST_US(5)) bbc_top_i (.clk(clk), .nrst(nrst),
    .en(en), .scl(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .pwm(pwm),
    .backlight_on(backlight_on), .sink_one_on(sink_one_on), .sink_two_on(sink_two_on),
    .target_code(target_code), .brightness_update(brightness_update));
  bbc_pwm_src bbc_pwm_src_i (.clk(clk), .run(run), .high_cyc(hi_cyc), .low_cyc(lo_cyc),
    .pwm(pwm));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk)
    if (brightness_update === 1'b1)
      n_upd <= n_upd + 1;

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bit_x(input logic b, output logic r);
    sda_m <= b;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    r = sda_w;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic bus_start();
    sda_m <= 1'b1;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_m <= 1'b0;
    tick(Q);
    scl <= 1'b0;
    tick(Q);
  endtask

  task automatic bus_stop();
    sda_m <= 1'b0;
    tick(Q);
    scl <= 1'b1;
    tick(Q);
    sda_m <= 1'b1;
    tick(2 * Q);
  endtask

  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] r,
    output logic a);
    for (int i = 7; i >= 0; i--)
      bit_x(d[i], r[i]);
    bit_x(last, a);
  endtask

  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] d);
    logic [7:0] r;
    logic a0, a1, a2;
    bus_start();
    xfer({ADDR, 1'b0}, 1'b1, r, a0);
    xfer(ptr, 1'b1, r, a1);
    xfer(d, 1'b1, r, a2);
    bus_stop();
    check(16'({a0, a1, a2}), 16'h0000);
  endtask

  task automatic reg_rd(input logic [7:0] ptr, output logic [7:0] d);
    logic [7:0] r;
    logic a;
    bus_start();
    xfer({ADDR, 1'b0}, 1'b1, r, a);
    xfer(ptr, 1'b1, r, a);
    bus_start();
    xfer({ADDR, 1'b1}, 1'b1, r, a);
    xfer(8'hff, 1'b1, d, a);
    bus_stop();
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0] rd;
    logic a;
    int u;
    nrst = 1'b0;
    en = 1'b1;
    scl = 1'b1;
    sda_m = 1'b1;
    run = 1'b0;
    hi_cyc = 8'h78;
    lo_cyc = 8'h3c;
    tick(10);
    nrst <= 1'b1;
    tick(5);
    foreach (OFFS[i])
    begin
      reg_rd(OFFS[i], rd);
      check(16'(rd), 16'h0000);
    end
    bus_start();
    xfer({~ADDR, 1'b0}, 1'b1, rd, a);
    bus_stop();
    check(16'(a), 16'h0001);
    done("reset_values");
    reg_wr(8'h0a, 8'h19);
    u = n_upd;
    reg_wr(8'h04, 8'h05);
    check(16'(n_upd - u), 16'h0000);
    check(16'(target_code), 16'h0000);
    reg_wr(8'h05, 8'ha3);
    check(16'(n_upd - u), 16'h0001);
    check(16'(target_code), 16'({8'ha3, 3'h5}));
    check(16'({backlight_on, sink_one_on, sink_two_on}), 16'h0007);
    reg_rd(8'h04, rd);
    check(16'(rd), 16'h0005);
    reg_wr(8'h04, 8'h02);
    check(16'(target_code), 16'({8'ha3, 3'h5}));
    reg_wr(8'h05, 8'h01);
    check(16'(target_code), 16'h000a);
    done("staging");
    for (int i = 0; i < 4; i++)
    begin
      reg_wr(8'h0a, EN_VAL[i]);
      check(16'({backlight_on, sink_one_on, sink_two_on}), 16'(EN_EXP[i]));
    end
    reg_wr(8'h0a, 8'h19);
    reg_wr(8'h04, 8'h00);
    reg_wr(8'h05, 8'h00);
    check(16'({backlight_on, target_code}), 16'h0000);
    done("enables");
    reg_wr(8'h05, 8'h80);
    run <= 1'b1;
    reg_wr(8'h09, 8'h40);
    tick(720);
    // 12 of 18 samples high on code 0x400
    check(16'(target_code), 16'h02aa);
    reg_wr(8'h02, 8'h08);
    tick(720);
    check(16'(target_code), 16'h0155);
    reg_wr(8'h02, 8'h00);
    tick(720);
    reg_wr(8'h05, 8'h00);
    check(16'(backlight_on), 16'h0000);
    reg_wr(8'h05, 8'h80);
    tick(360);
    check(16'(target_code), 16'h02aa);
    run <= 1'b0;
    tick(500);
    check(16'(backlight_on), 16'h0000);
    // status: timeout set, backlight off
    reg_rd(8'h0c, rd);
    check(16'(rd), 16'h0002);
    done("duty_slow");
    reg_wr(8'h03, 8'h04);
    hi_cyc <= 8'h14;
    lo_cyc <= 8'h14;
    run <= 1'b1;
    tick(400);
    check(16'(target_code), 16'h0200);
    run <= 1'b0;
    tick(80);
    // slow sampling would still be on here
    check(16'(backlight_on), 16'h0000);
    done("duty_fast");
    reg_wr(8'h09, 8'h00);
    check(16'(target_code), 16'h0400);
    en <= 1'b0;
    tick(10);
    check(16'(backlight_on), 16'h0000);
    en <= 1'b1;
    tick(5);
    reg_rd(8'h0a, rd);
    check(16'(rd), 16'h0000);
    done("chip_enable");
    tally_and_finish();
  end
endmodule

bind bbc_top bbc_top_sva #(.TIMEOUT_SLOW_US(TIMEOUT_SLOW_US), .TIMEOUT_FAST_US(TIMEOUT_FAST_US))
  bbc_top_sva_i (.clk(clk), .nrst(nrst), .en(en), .scl(scl), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .pwm(pwm), .backlight_on(backlight_on),
  .sink_one_on(sink_one_on), .sink_two_on(sink_two_on), .target_code(target_code),
  .brightness_update(brightness_update));
